// ===== hdl/tic_params.svh
// Purpose: Constants of the time interval counter: offsets, bits, resets,
//          limits and timebase figures.
// Assumes: Included by bare name; definitions only.
// Notes on behaviour
// - Day wrap set: hours wrap after 23; clear: count through 255.
// - Bits 5:4 pick interval rate: 1/128 s, seconds, minutes, hours.
// - One-shot set: single timeout, which clears the run enable bit.
// - One-shot clear: counter reloads and keeps counting after timeouts.
// - Flag bit 2 sets on match and holds until software clears it.
// - A set flag raises the CPU interrupt when its enable is on.
// - Run enable bit 1 lets the interval counter run or stops it.
// - Gate bit 0 stops all counters and restores last written times.
// - Time registers accept writes while the gate is low.
// - Match register at A6H holds an 8-bit compare value.
// - Fraction register A2H steps each 1/128 s, wraps after 127.
// - Seconds register A3H steps each second, wraps after 59.
// - Minutes register A4H steps each minute, wraps after 59.
// - Hours register A5H steps each hour, 23 wrap in day mode.
// - Match and time registers reset to zero.
// - Interval counter steps each time the selected time register steps.
// - Counters run from the 32.768 kHz crystal, also in power-down.
// - Flag with interrupt enabled in power-down wakes, vector 0053H.
`ifndef TIC_PARAMS_SVH
`define TIC_PARAMS_SVH

`define TIC_ADDR_CTL 8'ha1
`define TIC_ADDR_FRAC 8'ha2
`define TIC_ADDR_SEC 8'ha3
`define TIC_ADDR_MIN 8'ha4
`define TIC_ADDR_HOUR 8'ha5
`define TIC_ADDR_MATCH 8'ha6

`define TIC_BIT_DAY 6
`define TIC_BIT_TB_HI 5
`define TIC_BIT_TB_LO 4
`define TIC_BIT_ONESHOT 3
`define TIC_BIT_FLAG 2
`define TIC_BIT_RUN 1
`define TIC_BIT_GATE 0

`define TIC_RST_CTL 8'h00
`define TIC_RST_TIME 8'h00
`define TIC_RST_MATCH 8'h00

`define TIC_FRAC_MAX 8'h7f
`define TIC_SEC_MAX 8'h3b
`define TIC_MIN_MAX 8'h3b
`define TIC_HOUR_DAY_MAX 8'h17
`define TIC_HOUR_FULL_MAX 8'hff

`define TIC_XTAL_HZ 32768
`define TIC_TICK_HZ 128
`define TIC_XTAL_PER_TICK (`TIC_XTAL_HZ / `TIC_TICK_HZ)

`define TIC_VECTOR 16'h0053

`endif

// ===== hdl/tic_pkg.sv
// Purpose: Types shared by the time interval counter files.
// Assumes: Constants come from tic_params.svh.
// Notes: Timebase codes follow the control register field.
package tic_pkg;

  typedef logic [7:0] tic_byte_t;

  typedef enum logic [1:0] {
    TIC_TB_FRAC = 2'b00,
    TIC_TB_SEC = 2'b01,
    TIC_TB_MIN = 2'b10,
    TIC_TB_HOUR = 2'b11
  } tic_tb_t;

endpackage

// ===== hdl/tic_sync.sv
// Purpose: Two-stage synchroniser with rising-edge pulse.
// Assumes: Input is asynchronous to mclk.
// Notes: First stage feeds only the second stage.
`timescale 1ns/100ps
module tic_sync
  import tic_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic d,
  output logic rise
);

  logic s1_r, s2_r, s3_r;
  logic s1_nxt, s2_nxt, s3_nxt;

  always_comb begin
    s1_nxt = d;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  assign rise = s2_r & ~s3_r;

  a_rise_single: assert property (@(posedge mclk) disable iff (rst)
    rise |=> !rise) else $error("edge pulse longer than one cycle");

endmodule // tic_sync

// ===== hdl/tic_wrap_cnt.sv
// Purpose: One time register: loadable counter that wraps at a limit.
// Assumes: limit is stable around inc pulses.
// Notes: A load beats an increment in the same cycle.
`timescale 1ns/100ps
`include "tic_params.svh"
module tic_wrap_cnt
  import tic_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic inc,
  input wire logic [WIDTH-1:0] limit,
  output logic [WIDTH-1:0] count,
  output logic wrap
);

  logic [WIDTH-1:0] count_r, count_nxt;

  assign wrap = inc & ~load & (count_r == limit);

  always_comb begin
    count_nxt = count_r;
    if (load) begin
      count_nxt = load_val;
    end else if (wrap) begin
      count_nxt = '0;
    end else if (inc) begin
      count_nxt = count_r + WIDTH'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_r <= WIDTH'(`TIC_RST_TIME);
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;

  a_wrap_zero: assert property (@(posedge mclk) disable iff (rst)
    wrap |=> count_r == '0) else $error("wrap did not clear count");

endmodule // tic_wrap_cnt

// ===== hdl/tic_top.sv
// Purpose: Time interval counter: time of day from 1/128 s to hours and an
//          8-bit interval counter with compare flag and interrupt.
// Assumes: SFR strobes and int_en/power_down come from logic on mclk;
//          mclk keeps running in power-down; xtal_32k is asynchronous.
// Notes: Read data appears one cycle after the read strobe.
`timescale 1ns/100ps
`include "tic_params.svh"
module tic_top
  import tic_pkg::*;
#(
  parameter int XTAL_PER_TICK = `TIC_XTAL_PER_TICK
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic xtal_32k,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic int_en,
  input wire logic power_down,
  output logic irq,
  output logic wake,
  output logic [15:0] irq_vector
);

  localparam int PW = $clog2(XTAL_PER_TICK);

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  logic xtal_rise;
  logic tick;
  logic [PW-1:0] pre_r, pre_nxt;

  logic day_wrap_r, day_wrap_nxt;
  tic_tb_t tb_sel_r, tb_sel_nxt;
  logic one_shot_r, one_shot_nxt;
  logic flag_r, flag_nxt;
  logic run_en_r, run_en_nxt;
  logic gate_r, gate_nxt;
  tic_byte_t match_r, match_nxt;
  tic_byte_t iv_cnt_r, iv_cnt_nxt;
  logic iv_tick, iv_hit;

  tic_byte_t time_q [4];
  tic_byte_t shadow_r [4];
  tic_byte_t shadow_nxt [4];
  tic_byte_t lim [4];
  logic [3:0] carry;
  logic [3:0] wrap;
  logic [3:0] time_wr;
  logic ctl_wr, match_wr;

  tic_byte_t rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;
  logic wake_r, wake_nxt;
  logic [15:0] vec_r;

  tic_sync u_xtal_sync (
    .mclk(mclk),
    .rst(rst),
    .d(xtal_32k),
    .rise(xtal_rise)
  );

  always_comb begin
    pre_nxt = pre_r;
    if (!gate_r) begin
      pre_nxt = '0;
    end else if (xtal_rise) begin
      if (pre_r == PW'(XTAL_PER_TICK - 1)) begin
        pre_nxt = '0;
      end else begin
        pre_nxt = pre_r + PW'(1);
      end
    end
  end

  assign tick = gate_r & xtal_rise & (pre_r == PW'(XTAL_PER_TICK - 1));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  assign ctl_wr = sfr_wr & addr_is(sfr_addr, `TIC_ADDR_CTL);
  assign match_wr = sfr_wr & addr_is(sfr_addr, `TIC_ADDR_MATCH);

  // Control register; hardware events override a same-cycle write
  always_comb begin
    day_wrap_nxt = day_wrap_r;
    tb_sel_nxt = tb_sel_r;
    one_shot_nxt = one_shot_r;
    flag_nxt = flag_r;
    run_en_nxt = run_en_r;
    gate_nxt = gate_r;
    if (ctl_wr) begin
      day_wrap_nxt = sfr_wdata[`TIC_BIT_DAY];
      tb_sel_nxt = tic_tb_t'(sfr_wdata[`TIC_BIT_TB_HI:`TIC_BIT_TB_LO]);
      one_shot_nxt = sfr_wdata[`TIC_BIT_ONESHOT];
      run_en_nxt = sfr_wdata[`TIC_BIT_RUN];
      gate_nxt = sfr_wdata[`TIC_BIT_GATE];
      if (!sfr_wdata[`TIC_BIT_FLAG]) begin
        flag_nxt = 1'b0;
      end
    end
    if (iv_hit) begin
      flag_nxt = 1'b1;
      if (one_shot_r) begin
        run_en_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      day_wrap_r <= 1'(`TIC_RST_CTL >> `TIC_BIT_DAY);
      tb_sel_r <= TIC_TB_FRAC;
      one_shot_r <= 1'b0;
      flag_r <= 1'b0;
      run_en_r <= 1'b0;
      gate_r <= 1'b0;
    end else begin
      day_wrap_r <= day_wrap_nxt;
      tb_sel_r <= tb_sel_nxt;
      one_shot_r <= one_shot_nxt;
      flag_r <= flag_nxt;
      run_en_r <= run_en_nxt;
      gate_r <= gate_nxt;
    end
  end

  always_comb begin
    lim[0] = `TIC_FRAC_MAX;
    lim[1] = `TIC_SEC_MAX;
    lim[2] = `TIC_MIN_MAX;
    lim[3] = day_wrap_r ? `TIC_HOUR_DAY_MAX : `TIC_HOUR_FULL_MAX;
  end

  assign carry[0] = tick;

  // Live counters reload from the shadow copy whenever the gate is low,
  // so stopping the clock also rolls the time back to the last write.
  for (genvar i = 0; i < 4; i++) begin : g_time
    assign time_wr[i] = sfr_wr & addr_is(sfr_addr,
                                         `TIC_ADDR_FRAC + 8'(i));
    tic_wrap_cnt #(.WIDTH(8)) u_cnt (
      .mclk(mclk),
      .rst(rst),
      .load(time_wr[i] | ~gate_r),
      .load_val(time_wr[i] ? sfr_wdata : shadow_r[i]),
      .inc(carry[i] & gate_r),
      .limit(lim[i]),
      .count(time_q[i]),
      .wrap(wrap[i])
    );
    // Hour overflow feeds no counter and no interval rate
    if (i < 3) begin : g_carry
      assign carry[i+1] = wrap[i];
    end
  end

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      shadow_nxt[k] = time_wr[k] ? sfr_wdata : shadow_r[k];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < 4; k++) begin
        shadow_r[k] <= `TIC_RST_TIME;
      end
    end else begin
      for (int k = 0; k < 4; k++) begin
        shadow_r[k] <= shadow_nxt[k];
      end
    end
  end

  always_comb begin
    unique case (tb_sel_r)
      TIC_TB_FRAC: iv_tick = tick;
      TIC_TB_SEC: iv_tick = wrap[0];
      TIC_TB_MIN: iv_tick = wrap[1];
      TIC_TB_HOUR: iv_tick = wrap[2];
    endcase
  end

  assign iv_hit = iv_tick & run_en_r & ((iv_cnt_r + 8'h01) == match_r);

  always_comb begin
    iv_cnt_nxt = iv_cnt_r;
    match_nxt = match_wr ? sfr_wdata : match_r;
    if (!run_en_r) begin
      iv_cnt_nxt = 8'h00;
    end else if (iv_hit) begin
      iv_cnt_nxt = 8'h00;
    end else if (iv_tick) begin
      iv_cnt_nxt = iv_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      iv_cnt_r <= 8'h00;
      match_r <= `TIC_RST_MATCH;
    end else begin
      iv_cnt_r <= iv_cnt_nxt;
      match_r <= match_nxt;
    end
  end

  // whole-byte read in one mclk edge, never torn
  always_comb begin
    rdata_nxt = rdata_r;
    if (sfr_rd) begin
      rdata_nxt = 8'h00;
      if (addr_is(sfr_addr, `TIC_ADDR_CTL)) begin
        rdata_nxt[`TIC_BIT_DAY] = day_wrap_r;
        rdata_nxt[`TIC_BIT_TB_HI:`TIC_BIT_TB_LO] = tb_sel_r;
        rdata_nxt[`TIC_BIT_ONESHOT] = one_shot_r;
        rdata_nxt[`TIC_BIT_FLAG] = flag_r;
        rdata_nxt[`TIC_BIT_RUN] = run_en_r;
        rdata_nxt[`TIC_BIT_GATE] = gate_r;
      end else if (addr_is(sfr_addr, `TIC_ADDR_MATCH)) begin
        rdata_nxt = match_r;
      end else begin
        for (int k = 0; k < 4; k++) begin
          if (addr_is(sfr_addr, `TIC_ADDR_FRAC + 8'(k))) begin
            rdata_nxt = time_q[k];
          end
        end
      end
    end
  end

  always_comb begin
    irq_nxt = flag_r & int_en;
    wake_nxt = flag_r & int_en & power_down;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
      vec_r <= `TIC_VECTOR;
    end else begin
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      wake_r <= wake_nxt;
      vec_r <= `TIC_VECTOR;
    end
  end

  assign sfr_rdata = rdata_r;
  assign irq = irq_r;
  assign wake = wake_r;
  assign irq_vector = vec_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_hour_day_wrap: assert property (
    day_wrap_r && gate_r && wrap[2] && time_q[3] == 8'h17 && !time_wr[3]
    |=> time_q[3] == 8'h00) else $error("hour did not wrap after 23");

  a_sec_rate: assert property (
    tb_sel_r == TIC_TB_SEC && iv_tick |-> time_q[0] == 8'h7f && tick)
    else $error("seconds rate stepped off a second boundary");

  a_one_shot_stop: assert property (
    iv_hit && one_shot_r |=> !run_en_r && flag_r)
    else $error("one-shot timeout left counter running");

  a_auto_reload: assert property (
    iv_hit && !one_shot_r && !ctl_wr |=> run_en_r && iv_cnt_r == 8'h00)
    else $error("auto reload failed");

  a_flag_sticky: assert property (
    flag_r && !ctl_wr |=> flag_r) else $error("flag dropped by itself");

  a_irq_follow: assert property (
    flag_r && int_en |=> irq) else $error("interrupt not raised");

  a_stop_hold: assert property (
    !run_en_r |=> iv_cnt_r == 8'h00) else $error("stopped counter moved");

  a_gate_restore: assert property (
    !gate_r && !sfr_wr ##1 !sfr_wr |-> time_q[0] == shadow_r[0]
      && time_q[1] == shadow_r[1] && time_q[2] == shadow_r[2]
      && time_q[3] == shadow_r[3])
    else $error("time not restored while gate low");

  a_frac_wrap: assert property (
    tick && time_q[0] == 8'h7f && !time_wr[0] |=> time_q[0] == 8'h00)
    else $error("fraction did not wrap after 127");

  a_sec_carry: assert property (
    wrap[0] && time_q[1] == 8'h3b && !time_wr[1] |=> time_q[1] == 8'h00)
    else $error("seconds did not wrap after 59");

  a_match_zero: assert property (
    iv_hit |=> iv_cnt_r == 8'h00 && flag_r)
    else $error("counter not cleared on match");

  a_wake_req: assert property (
    flag_r && int_en && power_down |=> wake && irq_vector == 16'h0053)
    else $error("wake not raised in power-down");

  c_one_shot: cover property (iv_hit && one_shot_r);
  c_reload_twice: cover property (iv_hit && !one_shot_r ##[1:300] iv_hit);
  c_hour_wrap: cover property (wrap[3]);
  c_set_beats_clear: cover property (iv_hit && ctl_wr
    && !sfr_wdata[`TIC_BIT_FLAG]);

endmodule // tic_top

// ===== verification/test_time_interval_counter.sv
// Purpose: Self-checking bench for the time interval counter.
// Assumes: Inputs change on the falling edge of mclk; crystal edges are
//          made by the bench only in the tick task, also once with the gate low.
// Notes: A prescale of 4 crystal edges per tick keeps the run short.
`timescale 1ns/100ps
`include "tic_params.svh"
module test_time_interval_counter
  import tic_pkg::*;
;
  localparam int P = 4;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic xtal = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic int_en = 1'b0;
  logic pd = 1'b0;
  logic irq;
  logic wake;
  logic [15:0] vec;
  int n_errors = 0;
  int cmp_count = 0;

  always #5 mclk = ~mclk;

  tic_top #(.XTAL_PER_TICK(P)) i_dut (
    .mclk(mclk), .rst(rst), .xtal_32k(xtal), .sfr_addr(addr),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
    .int_en(int_en), .power_down(pd), .irq(irq), .wake(wake),
    .irq_vector(vec)
  );

  task automatic final_report();
    $display("Compares %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Strobe low for a cycle after each access so calls can follow directly
  task automatic wr_reg(input tic_byte_t a, input tic_byte_t d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
    @(negedge mclk);
  endtask

  task automatic rc(input tic_byte_t a, input tic_byte_t exp);
    addr = a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    chk({8'h00, rdata}, {8'h00, exp});
    @(negedge mclk);
  endtask

  task automatic preset(input tic_byte_t f, s, m, h);
    wr_reg(`TIC_ADDR_FRAC, f);
    wr_reg(`TIC_ADDR_SEC, s);
    wr_reg(`TIC_ADDR_MIN, m);
    wr_reg(`TIC_ADDR_HOUR, h);
  endtask

  // Extra wait covers the synchroniser and the counter cascade
  task automatic tick(input int n);
    repeat (n * P) begin
      xtal = 1'b1;
      repeat (3) @(negedge mclk);
      xtal = 1'b0;
      repeat (3) @(negedge mclk);
    end
    repeat (6) @(negedge mclk);
  endtask

  // Whole run is near 1,200 cycles; this bound only catches a hang
  initial begin
    repeat (30000) @(posedge mclk);
    n_errors++;
    final_report();
  end

  initial begin
    tic_byte_t t[3];
    tic_byte_t c;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    for (int a = 8'ha1; a <= 8'ha6; a++) rc(8'(a), 8'h00);
    chk(vec, `TIC_VECTOR);
    wr_reg(`TIC_ADDR_MATCH, 8'hff);
    rc(`TIC_ADDR_MATCH, 8'hff);
    wr_reg(8'ha0, 8'h5a);
    rc(8'ha0, 8'h00);
    preset(8'h7e, 8'h3b, 8'h3b, 8'h17);
    tick(1);
    rc(`TIC_ADDR_FRAC, 8'h7e);
    wr_reg(`TIC_ADDR_CTL, 8'h41);
    tick(1);
    rc(`TIC_ADDR_FRAC, 8'h7f);
    rc(`TIC_ADDR_SEC, 8'h3b);
    tick(1);
    rc(`TIC_ADDR_FRAC, 8'h00);
    rc(`TIC_ADDR_SEC, 8'h00);
    rc(`TIC_ADDR_MIN, 8'h00);
    rc(`TIC_ADDR_HOUR, 8'h00);
    wr_reg(`TIC_ADDR_CTL, 8'h40);
    rc(`TIC_ADDR_FRAC, 8'h7e);
    rc(`TIC_ADDR_HOUR, 8'h17);
    // full hour range without day wrap
    preset(8'h7f, 8'h3b, 8'h3b, 8'h17);
    wr_reg(`TIC_ADDR_CTL, 8'h01);
    tick(1);
    rc(`TIC_ADDR_HOUR, 8'h18);
    wr_reg(`TIC_ADDR_CTL, 8'h00);
    preset(8'h7f, 8'h3b, 8'h3b, 8'hff);
    wr_reg(`TIC_ADDR_CTL, 8'h01);
    tick(1);
    rc(`TIC_ADDR_HOUR, 8'h00);
    wr_reg(`TIC_ADDR_CTL, 8'h00);
    preset(8'h00, 8'h00, 8'h00, 8'h00);
    wr_reg(`TIC_ADDR_MATCH, 8'h03);
    int_en = 1'b1;
    wr_reg(`TIC_ADDR_CTL, 8'h01);
    tick(3);
    rc(`TIC_ADDR_CTL, 8'h01);
    // match on tick rate, flag holds, interrupt and wake
    wr_reg(`TIC_ADDR_CTL, 8'h03);
    tick(2);
    rc(`TIC_ADDR_CTL, 8'h03);
    chk(irq, 1'b0);
    tick(1);
    rc(`TIC_ADDR_CTL, 8'h07);
    chk(irq, 1'b1);
    chk(wake, 1'b0);
    pd = 1'b1;
    repeat (2) @(negedge mclk);
    chk(wake, 1'b1);
    pd = 1'b0;
    int_en = 1'b0;
    repeat (2) @(negedge mclk);
    chk(irq, 1'b0);
    chk(wake, 1'b0);
    int_en = 1'b1;
    tick(3);
    rc(`TIC_ADDR_CTL, 8'h07);
    // reload period stays exact after a timeout; one-shot timeout stops the counter
    wr_reg(`TIC_ADDR_CTL, 8'h03);
    rc(`TIC_ADDR_CTL, 8'h03);
    tick(2);
    rc(`TIC_ADDR_CTL, 8'h03);
    tick(1);
    rc(`TIC_ADDR_CTL, 8'h07);
    wr_reg(`TIC_ADDR_CTL, 8'h00);
    wr_reg(`TIC_ADDR_MATCH, 8'h02);
    wr_reg(`TIC_ADDR_CTL, 8'h0b);
    tick(2);
    rc(`TIC_ADDR_CTL, 8'h0d);
    wr_reg(`TIC_ADDR_CTL, 8'h09);
    tick(2);
    rc(`TIC_ADDR_CTL, 8'h09);
    // seconds, minutes and hours rates each step only on the overflow of the register below
    for (int tb = 1; tb <= 3; tb++) begin
      for (int neg = 0; neg < 2; neg++) begin
        t = '{8'h7e, 8'h3b, 8'h3b};
        for (int i = 0; i < 3; i++) if (i >= tb) t[i] = 8'h00;
        if (neg == 1) t[tb-1] = 8'h00;
        c = {2'b00, 2'(tb), 4'b0011};
        wr_reg(`TIC_ADDR_CTL, 8'h00);
        preset(t[0], t[1], t[2], 8'h00);
        wr_reg(`TIC_ADDR_MATCH, 8'h01);
        wr_reg(`TIC_ADDR_CTL, c);
        tick(1);
        rc(`TIC_ADDR_CTL, c);
        tick(1);
        rc(`TIC_ADDR_CTL, (neg == 1) ? c : (c | 8'h04));
      end
    end
    final_report();
  end
endmodule // test_time_interval_counter
